/* File: design/isal_lane_if.sv */
// Carrier between the lane sequencer and the lane steering logic
`timescale 1ns/1ns
`default_nettype none
interface isal_lane_if;
	logic [1:0] idx;
	logic word;
	logic is16;
	logic [31:0] wdata;
	logic [15:0] sd_in;
	logic [15:0] wr_lanes;
	logic [7:0] rd_lo;
	logic [7:0] rd_hi;
	modport seq (output idx, word, is16, wdata, sd_in, input wr_lanes, rd_lo, rd_hi);
	modport steer (input idx, word, is16, wdata, sd_in, output wr_lanes, rd_lo, rd_hi);
endinterface : isal_lane_if
`default_nettype wire

/* File: design/isal_lane_steer.sv */
// Byte lane steering between the 32-bit CPU word and the 16-bit ISA data bus
`timescale 1ns/1ns
`default_nettype none
module isal_lane_steer (
	isal_lane_if.steer ln
);
	logic [7:0] byte_sel;
	logic [7:0] byte_up;

	always_comb
	begin
		byte_sel = ln.wdata[8 * ln.idx +: 8];
		byte_up = ln.wdata[8 * {ln.idx[1], 1'b1} +: 8];
		// Word at an even address; single bytes appear on both lanes
		if (ln.word)
		begin
			ln.wr_lanes = {byte_up, byte_sel};
		end
		else
		begin
			ln.wr_lanes = {byte_sel, byte_sel};
		end
		ln.rd_hi = ln.sd_in[15:8];
		// A 16-bit device returns an odd byte on the upper lane, an 8-bit one on the low lane
		if (!ln.word && ln.is16 && ln.idx[0])
		begin
			ln.rd_lo = ln.sd_in[15:8];
		end
		else
		begin
			ln.rd_lo = ln.sd_in[7:0];
		end
	end
endmodule : isal_lane_steer
`default_nettype wire

/* File: design/isal_lanes.sv */
// ISA address, byte-lane and data-lane sequencer for CPU accesses
`timescale 1ns/1ns
`default_nettype none
module isal_lanes (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic cpu_start,
	input wire logic cpu_write,
	input wire logic cpu_mem,
	input wire logic [23:2] cpu_addr,
	input wire logic [3:0] cpu_byte_enables,
	input wire logic [31:0] cpu_wdata,
	output logic cpu_busy,
	output logic cpu_done,
	output logic [31:0] cpu_rdata,
	output logic [23:0] isa_addr,
	output logic sbhe_n,
	output logic [15:0] sd_o,
	output logic sd_oe,
	input wire logic [15:0] sd_i,
	output logic memr_n,
	output logic memw_n,
	output logic smemr_n,
	output logic smemw_n,
	output logic ior_n,
	output logic iow_n,
	input wire logic iocs16_n,
	input wire logic memcs16_n,
	input wire logic iochrdy
);
	isal_pkg::isal_state_t state_r;
	logic [3:0] cnt_r;
	logic [3:0] rem_r;
	logic write_r;
	logic mem_r;
	logic [31:0] wdata_r;
	logic [1:0] idx_r;
	logic word_try_r;
	logic word_r;
	logic is16_r;
	logic [15:0] sd_m_r;
	logic [15:0] sd_s_r;
	logic [2:0] pin_m_r;
	logic [2:0] pin_s_r;
	logic [1:0] idx_nxt;
	logic word_try_nxt;
	logic cs16_sel;
	logic small_mem;
	logic ready;
	logic [3:0] rem_nxt;
	logic [3:0] done_mask;

	isal_lane_if ln ();
	isal_lane_steer u_steer (
		.ln(ln)
	);

	assign ln.idx = idx_r;
	// Lanes follow the tried word from the address phase so write data settles before the strobe
	assign ln.word = word_try_r;
	assign ln.is16 = is16_r;
	assign ln.wdata = wdata_r;
	assign ln.sd_in = sd_s_r;

	// Pin inputs pass two flip-flops before use
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			pin_m_r <= 3'h7;
			pin_s_r <= 3'h7;
			sd_m_r <= 16'h0000;
			sd_s_r <= 16'h0000;
		end
		else
		begin
			pin_m_r <= {iochrdy, memcs16_n, iocs16_n};
			pin_s_r <= pin_m_r;
			sd_m_r <= sd_i;
			sd_s_r <= sd_m_r;
		end
	end

	// Width request follows the cycle type of this access
	assign cs16_sel = mem_r ? !pin_s_r[1] : !pin_s_r[0];
	assign ready = pin_s_r[2];
	assign small_mem = (isa_addr[isal_pkg::ADDR_W - 1:isal_pkg::SMALL_LSB] == isal_pkg::SMALL_TOP);
	assign cpu_busy = (state_r != isal_pkg::ISAL_IDLE);

	// Lowest enabled byte is next; try a word when its even pair is also enabled
	always_comb
	begin
		rem_nxt = (state_r == isal_pkg::ISAL_IDLE) ? cpu_byte_enables : rem_r;
		idx_nxt = 2'h3;
		if (rem_nxt[0])
			idx_nxt = 2'h0;
		else if (rem_nxt[1])
			idx_nxt = 2'h1;
		else if (rem_nxt[2])
			idx_nxt = 2'h2;
		word_try_nxt = !idx_nxt[0] && rem_nxt[idx_nxt + 2'h1];
		done_mask = 4'h1 << idx_r;
		if (word_r)
			done_mask = done_mask | (4'h2 << idx_r);
	end

	// Sequencer
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			state_r <= isal_pkg::ISAL_IDLE;
			cnt_r <= 4'h0;
			rem_r <= isal_pkg::BE_NONE;
			idx_r <= 2'h0;
			word_try_r <= 1'b0;
			word_r <= 1'b0;
			is16_r <= 1'b0;
			cpu_done <= 1'b0;
		end
		else
		begin
			cpu_done <= 1'b0;
			case (state_r)
				isal_pkg::ISAL_IDLE:
				begin
					if (cpu_start)
					begin
						if (cpu_byte_enables == isal_pkg::BE_NONE)
							cpu_done <= 1'b1;
						else
						begin
							rem_r <= cpu_byte_enables;
							idx_r <= idx_nxt;
							word_try_r <= word_try_nxt;
							word_r <= 1'b0;
							cnt_r <= isal_pkg::ADDR_CYC;
							state_r <= isal_pkg::ISAL_ADDR;
						end
					end
				end
				isal_pkg::ISAL_ADDR:
				begin
					if (cnt_r <= 4'h1)
					begin
						// Width fixed on the edge that asserts the strobe, from the synchronised select
						is16_r <= cs16_sel;
						word_r <= word_try_r && cs16_sel;
						cnt_r <= isal_pkg::CMD_CYC;
						state_r <= isal_pkg::ISAL_CMD;
					end
					else
						cnt_r <= cnt_r - 4'h1;
				end
				isal_pkg::ISAL_CMD:
				begin
					if (cnt_r > 4'h1)
						cnt_r <= cnt_r - 4'h1;
					else if (ready)
					begin
						rem_r <= rem_r & ~done_mask;
						cnt_r <= isal_pkg::RECOV_CYC;
						state_r <= isal_pkg::ISAL_RECOV;
					end
				end
				isal_pkg::ISAL_RECOV:
				begin
					if (cnt_r > 4'h1)
						cnt_r <= cnt_r - 4'h1;
					else if (rem_r == isal_pkg::BE_NONE)
					begin
						cpu_done <= 1'b1;
						state_r <= isal_pkg::ISAL_IDLE;
					end
					else
					begin
						idx_r <= idx_nxt;
						word_try_r <= word_try_nxt;
						word_r <= 1'b0;
						cnt_r <= isal_pkg::ADDR_CYC;
						state_r <= isal_pkg::ISAL_ADDR;
					end
				end
				default:
					state_r <= isal_pkg::ISAL_IDLE;
			endcase
		end
	end

	// Access attributes and upper address held for the whole access; address bits 1:0 move to the next byte in recovery
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			write_r <= 1'b0;
			mem_r <= 1'b0;
			wdata_r <= 32'h00000000;
			isa_addr <= 24'h000000;
		end
		else if (state_r == isal_pkg::ISAL_IDLE && cpu_start)
		begin
			write_r <= cpu_write;
			mem_r <= cpu_mem;
			wdata_r <= cpu_wdata;
			isa_addr <= {cpu_addr, idx_nxt};
		end
		else if (state_r == isal_pkg::ISAL_RECOV && cnt_r <= 4'h1 && rem_r != isal_pkg::BE_NONE)
			isa_addr[1:0] <= idx_nxt;
	end

	// High-byte enable for odd bytes and attempted words, stable through the cycle
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			sbhe_n <= 1'b1;
		else if (state_r == isal_pkg::ISAL_IDLE && cpu_start && cpu_byte_enables != isal_pkg::BE_NONE)
			sbhe_n <= !(idx_nxt[0] || word_try_nxt);
		else if (state_r == isal_pkg::ISAL_RECOV && cnt_r <= 4'h1)
			sbhe_n <= (rem_r == isal_pkg::BE_NONE) || !(idx_nxt[0] || word_try_nxt);
	end

	// Command strobes and the small-memory copies
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			memr_n <= 1'b1;
			memw_n <= 1'b1;
			smemr_n <= 1'b1;
			smemw_n <= 1'b1;
			ior_n <= 1'b1;
			iow_n <= 1'b1;
		end
		else
		begin
			memr_n <= 1'b1;
			memw_n <= 1'b1;
			smemr_n <= 1'b1;
			smemw_n <= 1'b1;
			ior_n <= 1'b1;
			iow_n <= 1'b1;
			if ((state_r == isal_pkg::ISAL_ADDR && cnt_r <= 4'h1)
				|| (state_r == isal_pkg::ISAL_CMD && !(cnt_r <= 4'h1 && ready)))
			begin
				memr_n <= !(mem_r && !write_r);
				memw_n <= !(mem_r && write_r);
				smemr_n <= !(mem_r && !write_r && small_mem);
				smemw_n <= !(mem_r && write_r && small_mem);
				ior_n <= !(!mem_r && !write_r);
				iow_n <= !(!mem_r && write_r);
			end
		end
	end

	// Write data driven through address and command phases
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			sd_o <= 16'h0000;
			sd_oe <= 1'b0;
		end
		else
		begin
			sd_o <= ln.wr_lanes;
			sd_oe <= write_r && (state_r == isal_pkg::ISAL_ADDR || state_r == isal_pkg::ISAL_CMD)
				&& !(state_r == isal_pkg::ISAL_CMD && cnt_r <= 4'h1 && ready);
		end
	end

	// Read data captured into its CPU byte lanes at the end of the strobe
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			cpu_rdata <= isal_pkg::RDATA_RST;
		else if (state_r == isal_pkg::ISAL_CMD && cnt_r <= 4'h1 && ready && !write_r)
		begin
			cpu_rdata[8 * idx_r +: 8] <= ln.rd_lo;
			if (word_r)
				cpu_rdata[8 * {idx_r[1], 1'b1} +: 8] <= ln.rd_hi;
		end
	end
endmodule : isal_lanes
`default_nettype wire

/* File: design/isal_pkg.sv */
// Constants shared by the ISA address and data lane logic
package isal_pkg;
	localparam int CLK_MHZ = 10;
	// Address setup ahead of a command strobe, strobe width, recovery (ns)
	localparam int ADDR_NS = 300;
	localparam int CMD_NS = 500;
	localparam int RECOV_NS = 200;
	localparam logic [3:0] ADDR_CYC = 4'((ADDR_NS * CLK_MHZ + 999) / 1000);
	localparam logic [3:0] CMD_CYC = 4'((CMD_NS * CLK_MHZ + 999) / 1000);
	localparam logic [3:0] RECOV_CYC = 4'((RECOV_NS * CLK_MHZ + 999) / 1000);
	localparam int ADDR_W = 24;
	localparam int SMALL_LSB = 20;
	localparam logic [3:0] SMALL_TOP = 4'h0;
	localparam logic [3:0] BE_NONE = 4'h0;
	localparam logic [31:0] RDATA_RST = 32'h00000000;
	typedef enum logic [3:0] {
		ISAL_IDLE = 4'b0001,
		ISAL_ADDR = 4'b0010,
		ISAL_CMD = 4'b0100,
		ISAL_RECOV = 4'b1000
	} isal_state_t;
endpackage : isal_pkg

/* File: sim/isal_chk.sv */
// Port-level assertions for the ISA lane sequencer
`timescale 1ns/1ns
`default_nettype none
module isal_chk (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic cpu_start,
	input wire logic cpu_busy,
	input wire logic cpu_done,
	input wire logic [23:2] cpu_addr,
	input wire logic [3:0] cpu_byte_enables,
	input wire logic [23:0] isa_addr,
	input wire logic sbhe_n,
	input wire logic [15:0] sd_o,
	input wire logic sd_oe,
	input wire logic memr_n,
	input wire logic memw_n,
	input wire logic smemr_n,
	input wire logic smemw_n,
	input wire logic ior_n,
	input wire logic iow_n
);
	wire logic cmd = !(memr_n && memw_n && ior_n && iow_n);
	wire logic wr = !(memw_n && iow_n);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);
	smem_rd_a: assert property (smemr_n == (memr_n || isa_addr[23:20] != 4'h0))
		else $error("small read strobe wrong");
	smem_wr_a: assert property (smemw_n == (memw_n || isa_addr[23:20] != 4'h0))
		else $error("small write strobe wrong");
	addr_hold_a: assert property (cmd && $past(cmd) |-> $stable(isa_addr) && $stable(sbhe_n))
		else $error("address moved under strobe");
	addr_src_a: assert property (cmd |-> isa_addr[23:2] == cpu_addr && cpu_byte_enables[isa_addr[1:0]])
		else $error("address not from request");
	odd_hi_a: assert property (cmd && isa_addr[0] |-> !sbhe_n)
		else $error("odd byte without high enable");
	word_try_a: assert property (cmd && !sbhe_n && !isa_addr[0] |-> cpu_byte_enables[isa_addr[1:0] + 2'h1])
		else $error("high enable with no high byte");
	odd_lanes_a: assert property (wr && isa_addr[0] |-> sd_o[7:0] == sd_o[15:8] && sd_oe)
		else $error("odd write byte not on both lanes");
	no_piece_a: assert property (cpu_start && !cpu_busy && cpu_byte_enables == 4'h0 |=> cpu_done)
		else $error("empty access not done at once");
	busy_set_a: assert property (cpu_start && !cpu_busy |=> cpu_busy != cpu_done)
		else $error("start gave neither busy nor done");
	cover property (cmd && !sbhe_n && !isa_addr[0]);
	cover property (!smemw_n);
	cover property ($fell(ior_n) && isa_addr[0]);
endmodule : isal_chk
bind isal_lanes isal_chk chk_u (.sys_clk, .rstn, .cpu_start, .cpu_busy, .cpu_done, .cpu_addr,
	.cpu_byte_enables, .isa_addr, .sbhe_n, .sd_o, .sd_oe, .memr_n, .memw_n, .smemr_n,
	.smemw_n, .ior_n, .iow_n);
`default_nettype wire

/* File: sim/isal_periph.sv */
// Behavioural ISA peripheral with a 16-byte store
`timescale 1ns/1ns
`default_nettype none
module isal_periph (
	input wire logic sys_clk,
	input wire logic io_wide,
	input wire logic mem_wide,
	input wire logic slow,
	input wire logic [23:0] isa_addr,
	input wire logic sbhe_n,
	input wire logic [15:0] sd_o,
	input wire logic memr_n,
	input wire logic memw_n,
	input wire logic ior_n,
	input wire logic iow_n,
	output logic [15:0] sd_i,
	output logic iocs16_n,
	output logic memcs16_n,
	output logic iochrdy
);
	logic [7:0] mem [16];
	logic [3:0] wait_r = 4'h0;
	logic junk_r = 1'b0;
	logic wide;
	logic cmd;
	logic [3:0] a;
	assign a = isa_addr[3:0];
	assign cmd = !(memr_n && memw_n && ior_n && iow_n);
	// Selects come from a static decode, ready of any strobe
	assign iocs16_n = !io_wide;
	assign memcs16_n = !mem_wide;
	// Cycle type is known only from the strobe
	assign wide = (memr_n && memw_n) ? io_wide : mem_wide;
	assign iochrdy = !(slow && cmd && wait_r < 4'h6);
	// Undriven bus toggles so a stale value never matches
	always_comb
		if (!(memr_n && ior_n))
			sd_i = wide ? (a[0] ? {mem[a], ~mem[a]} : {mem[a + 4'h1], mem[a]})
				: {~mem[a], mem[a]};
		else
			sd_i = {16{junk_r}};
	initial
		for (int i = 0; i < 16; i++)
			mem[i] = 8'h00;
	always @(posedge sys_clk)
	begin
		junk_r <= !junk_r;
		wait_r <= cmd ? wait_r + 4'h1 : 4'h0;
		if (!(memw_n && iow_n))
			if (!wide)
				mem[a] <= sd_o[7:0];
			else if (a[0])
				mem[a] <= sd_o[15:8];
			else
			begin
				mem[a] <= sd_o[7:0];
				if (!sbhe_n)
					mem[a + 4'h1] <= sd_o[15:8];
			end
	end
endmodule : isal_periph
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench: random writes and readbacks through the lanes
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic sys_clk, rstn, cpu_start, cpu_write, cpu_mem, cpu_busy, cpu_done;
	logic [23:2] cpu_addr, ad;
	logic [3:0] cpu_byte_enables;
	logic [31:0] cpu_wdata, cpu_rdata, exp_rd;
	logic [23:0] isa_addr;
	logic [15:0] sd_o, sd_i;
	logic sbhe_n, sd_oe, memr_n, memw_n, smemr_n, smemw_n, ior_n, iow_n;
	logic iocs16_n, memcs16_n, iochrdy, io_wide, mem_wide, slow, m, cmd_q;
	logic [7:0] ref_m [16];
	int num_errors, samples_checked, cyc, pieces;
	isal_lanes dut_u (.sys_clk, .rstn, .cpu_start, .cpu_write, .cpu_mem, .cpu_addr,
		.cpu_byte_enables, .cpu_wdata, .cpu_busy, .cpu_done, .cpu_rdata, .isa_addr, .sbhe_n,
		.sd_o, .sd_oe, .sd_i, .memr_n, .memw_n, .smemr_n, .smemw_n, .ior_n, .iow_n,
		.iocs16_n, .memcs16_n, .iochrdy);
	isal_periph per_u (.sys_clk, .io_wide, .mem_wide, .slow, .isa_addr, .sbhe_n, .sd_o,
		.memr_n, .memw_n, .ior_n, .iow_n, .sd_i, .iocs16_n, .memcs16_n, .iochrdy);
	task print_verdict;
		$display("checked %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD %0t saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	// ISA cycles for an access: a byte each, an even word where the width allows
	function automatic int exp_pieces(input logic [3:0] b, input logic wide);
		int p;
		p = 0;
		for (int i = 0; i < 4; i++)
			if (b[i] && !(wide && i % 2 == 1 && b[i - 1]))
				p++;
		return p;
	endfunction : exp_pieces
	task access(input logic w, input logic [3:0] b, input logic [31:0] d);
		int n, p0;
		@(negedge sys_clk);
		{cpu_write, cpu_mem, cpu_addr, cpu_byte_enables, cpu_wdata} = {w, m, ad, b, d};
		cpu_start = 1'b1;
		p0 = pieces;
		@(negedge sys_clk);
		cpu_start = 1'b0;
		n = 0;
		while (cpu_done !== 1'b1 && n < 300)
		begin
			@(negedge sys_clk);
			n++;
		end
		chk({31'h0, cpu_done}, 32'h1);
		chk(pieces - p0, exp_pieces(b, m ? mem_wide : io_wide));
		for (int i = 0; i < 4; i++)
			if (b[i] && w)
				ref_m[{ad[3:2], 2'(i)}] = d[i * 8 +: 8];
			else if (b[i])
				exp_rd[i * 8 +: 8] = ref_m[{ad[3:2], 2'(i)}];
	endtask : access
	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = !sys_clk;
	end
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			num_errors++;
			print_verdict();
		end
	end
	// One command strobe per ISA cycle
	always @(posedge sys_clk)
	begin
		cmd_q <= !(memr_n && memw_n && ior_n && iow_n);
		if (!cmd_q && !(memr_n && memw_n && ior_n && iow_n))
			pieces++;
	end
	initial
	begin
		{rstn, cpu_start, cpu_write, cpu_mem, cpu_addr, cpu_byte_enables, cpu_wdata} = '0;
		{io_wide, mem_wide, slow, m, ad, exp_rd} = '0;
		for (int i = 0; i < 16; i++)
			ref_m[i] = 8'h00;
		void'($urandom(1801));
		repeat (5) @(negedge sys_clk);
		rstn = 1'b1;
		for (int k = 0; k < 40; k++)
		begin
			ad = 22'($urandom);
			if (k % 2 == 1)
				ad[23:20] = 4'h0;
			// Early passes: one select only, the other cycle type, then slow ready
			{io_wide, mem_wide, slow} = k < 4 ? 3'(12'b001111100010 >> (k * 3)) : 3'($urandom);
			m = k < 4 ? k[0] : 1'($urandom);
			access(1'b1, k < 8 ? 4'hF : 4'($urandom), $urandom);
			access(1'b0, k < 4 ? 4'(16'h906F >> (k * 4)) : 4'($urandom), $urandom);
			chk(cpu_rdata, exp_rd);
		end
		print_verdict();
	end
endmodule : tb
`default_nettype wire
